// ---- rtl/oct_pkg.sv ----
package oct_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h80;
  localparam logic [7:0] IDX_COMPARE_FORCE  = 8'h81;
  localparam logic [7:0] IDX_CH7_MASK       = 8'h82;
  localparam logic [7:0] IDX_CH7_DATA       = 8'h83;
  localparam logic [7:0] IDX_MAIN_COUNTER   = 8'h84;
  localparam logic [7:0] IDX_MAIN_COUNTER_L = 8'h85;
  localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h86;
  localparam logic [7:0] IDX_RESERVED_QUEUE = 8'h87;
  localparam logic [7:0] IDX_ACTION_UPPER   = 8'h88;
  localparam logic [7:0] IDX_ACTION_LOWER   = 8'h89;
  localparam logic [7:0] IDX_PRESCALE_SEL   = 8'h8d;
  localparam logic [7:0] IDX_COMPARE_BASE   = 8'h90;
  localparam logic [7:0] IDX_COMPARE_LAST   = 8'h9f;
  localparam logic [7:0] IDX_PULSE_THREE    = 8'ha2;
  localparam logic [7:0] IDX_PULSE_TWO      = 8'ha3;
  localparam logic [7:0] IDX_PULSE_ONE      = 8'ha4;
  localparam logic [7:0] IDX_PULSE_ZERO     = 8'ha5;
  localparam logic [7:0] IDX_MODULUS_HI     = 8'hb6;
  localparam logic [7:0] IDX_MODULUS_LO     = 8'hb7;
  // System control bit positions
  localparam int BIT_TIMER_ON     = 7;
  localparam int BIT_STOP_IN_WAIT = 6;
  localparam int BIT_STOP_IN_DBG  = 5;
  localparam int BIT_FAST_CLEAR   = 4;
  // Reset values and the counter top
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_COUNTER = 16'h0000;
  localparam logic [15:0] COUNTER_TOP = 16'hffff;
  // Prescaler: divide-by-64 tap
  localparam logic [5:0]  DIV64_MASK  = 6'h3f;
  // Output action encodings
  typedef enum logic [1:0] {
    ACT_OFF    = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW    = 2'b10,
    ACT_HIGH   = 2'b11
  } oct_action_e;
endpackage

// ---- rtl/oct_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Run control and prescaler ticks between control and prescaler
interface oct_tick_if;
  logic       run;
  logic [2:0] pr_sel;
  logic       cnt_tick;
  logic       div64_tick;
  modport ctl (output run, output pr_sel, input cnt_tick, input div64_tick);
  modport pre (input run, input pr_sel, output cnt_tick, output div64_tick);
endinterface
`default_nettype wire

// ---- rtl/oct_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
// Prescaler, counting only while running, giving counter and divide-by-64 enable pulses
module oct_prescaler #(
  parameter int PRE_BITS = 7
) (
  input  wire logic clk,
  input  wire logic rst_n,
  oct_tick_if.pre   tk
);
  logic [PRE_BITS-1:0] cnt_q;
  logic [2:0]          pr_q;
  logic [PRE_BITS-1:0] mask;

  // Divide-by-64 tap and all seven stages need at least seven bits
  if (PRE_BITS < 7)
  begin : g_bad_bits
    $error("PRE_BITS must be at least 7");
  end

  assign mask = PRE_BITS'((1 << pr_q) - 1);

  // Stages run only while the timer is active
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) cnt_q <= '0;
    else if (tk.run) cnt_q <= cnt_q + 1'b1;
  end

  // New factor taken only where all stages are zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) pr_q <= 3'h0;
    else if (cnt_q == '0) pr_q <= tk.pr_sel;
  end

  // Tick pulses, none while stopped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tk.cnt_tick   <= 1'b0;
      tk.div64_tick <= 1'b0;
    end
    else
    begin
      tk.cnt_tick   <= tk.run && ((cnt_q & mask) == mask);
      tk.div64_tick <= tk.run && (cnt_q[5:0] == oct_pkg::DIV64_MASK);
    end
  end
endmodule // oct_prescaler
`default_nettype wire

// ---- rtl/oct_timer.sv ----
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Output compare and main counter control with AHB-Lite registers
module oct_timer #(
  parameter int CH_COUNT = 8
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:0]  PORT_DIRECTION,
  input  wire logic [7:0]  PORT_LATCH,
  input  wire logic        SPECIAL_MODE_LOW,
  input  wire logic        WAIT_MODE,
  input  wire logic        DEBUG_MODE,
  output logic      [7:0]  TIMER_PORT_OUT,
  output logic      [7:0]  TIMER_PORT_OE,
  output logic      [7:0]  COMPARE_EVENT,
  output logic             OVERFLOW_EVENT,
  output logic             DIV64_TICK,
  output logic             ACC_RUN,
  output logic             MODULUS_RUN,
  output logic      [7:0]  CLR_CHANNEL_FLAG,
  output logic             CLR_OVERFLOW_FLAG,
  output logic             CLR_ACC_A_FLAGS,
  output logic             CLR_ACC_B_FLAG,
  output logic             CLR_MODULUS_ZERO_FLAG
);
  logic        rst_meta_q;
  logic        rst_n;
  logic        sel_ok;
  logic        wr_q;
  logic        acc_q;
  logic [7:0]  idx_q;
  logic [7:0]  idx_a;
  logic        acc_rd;
  logic        acc_wr;
  logic [31:0] rdata_d;
  logic [7:0]  channel_is_compare_q;
  logic [7:0]  ch7_output_mask_q;
  logic [7:0]  ch7_output_data_q;
  logic [15:0] main_counter_q;
  logic [7:0]  control_q;
  logic [7:0]  output_action_upper_q;
  logic [7:0]  output_action_lower_q;
  logic [2:0]  prescale_sel_q;
  logic [15:0] channel_compare_value_q [CH_COUNT];
  logic [7:0]  compare_output_line_q;
  logic [7:0]  force_bits;
  logic [7:0]  match;
  logic [7:0]  act;
  logic [7:0]  drive;
  logic [7:0]  line_d;
  logic        wr_ok;
  logic        fast;
  logic        stop_wait;
  logic        stop_dbg;

  oct_tick_if tk ();

  // Eight channels are wired into the byte registers
  if (CH_COUNT != 8)
  begin : g_bad_count
    $error("CH_COUNT must be 8");
  end

  // Per-channel action pair from the two action registers
  function automatic logic [1:0] pair_of(input logic [7:0] up, input logic [7:0] lo,
                                         input int n);
    logic [15:0] all;
    all = {up, lo};
    return all[2*n +: 2];
  endfunction

  // Next line level for an action
  function automatic logic apply_action(input logic [1:0] pair, input logic cur);
    case (pair)
      oct_pkg::ACT_TOGGLE: return ~cur;
      oct_pkg::ACT_LOW:    return 1'b0;
      oct_pkg::ACT_HIGH:   return 1'b1;
      default:             return cur;
    endcase
  endfunction

  // Channel number of a compare register index
  function automatic int chan_of(input logic [7:0] idx);
    return int'(idx - oct_pkg::IDX_COMPARE_BASE) >> 1;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  oct_prescaler #(.PRE_BITS(7)) u_pre (
    .clk   (CLK),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // Run conditions for timer, accumulators, modulus counter
  assign fast      = control_q[oct_pkg::BIT_FAST_CLEAR];
  assign stop_wait = WAIT_MODE && control_q[oct_pkg::BIT_STOP_IN_WAIT];
  assign stop_dbg  = DEBUG_MODE && control_q[oct_pkg::BIT_STOP_IN_DBG];
  assign tk.run    = control_q[oct_pkg::BIT_TIMER_ON] && !stop_wait && !stop_dbg;
  assign tk.pr_sel = prescale_sel_q;

  // Address phase decode
  assign sel_ok = HSEL && HTRANS[1] && HREADY;
  assign idx_a  = (HADDR[31:10] == '0) ? HADDR[9:2] : 8'h00;
  assign acc_rd = sel_ok && !HWRITE;
  assign acc_wr = acc_q && wr_q;

  // Address phase capture for the data phase
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 1'b0;
      wr_q  <= 1'b0;
      idx_q <= 8'h00;
    end
    else
    begin
      acc_q <= sel_ok;
      wr_q  <= HWRITE;
      idx_q <= idx_a;
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Read mux, unmapped and reserved read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (idx_a)
      oct_pkg::IDX_CHANNEL_SELECT: rdata_d[7:0] = channel_is_compare_q;
      oct_pkg::IDX_COMPARE_FORCE:  rdata_d[7:0] = 8'h00;
      oct_pkg::IDX_CH7_MASK:       rdata_d[7:0] = ch7_output_mask_q;
      oct_pkg::IDX_CH7_DATA:       rdata_d[7:0] = ch7_output_data_q;
      oct_pkg::IDX_MAIN_COUNTER:   rdata_d[15:0] = main_counter_q;
      oct_pkg::IDX_SYSTEM_CONTROL: rdata_d[7:0] = control_q;
      oct_pkg::IDX_ACTION_UPPER:   rdata_d[7:0] = output_action_upper_q;
      oct_pkg::IDX_ACTION_LOWER:   rdata_d[7:0] = output_action_lower_q;
      oct_pkg::IDX_PRESCALE_SEL:   rdata_d[2:0] = prescale_sel_q;
      default:
      begin
        if (idx_a >= oct_pkg::IDX_COMPARE_BASE && idx_a <= oct_pkg::IDX_COMPARE_LAST
            && !idx_a[0])
          rdata_d[15:0] = channel_compare_value_q[chan_of(idx_a)];
      end
    endcase
  end

  // Read data registered at address phase
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n) HRDATA <= 32'h0000_0000;
    else if (acc_rd) HRDATA <= rdata_d;
  end

  // Control register writes
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_is_compare_q  <= oct_pkg::RST_BYTE;
      ch7_output_mask_q     <= oct_pkg::RST_BYTE;
      ch7_output_data_q     <= oct_pkg::RST_BYTE;
      control_q             <= oct_pkg::RST_BYTE;
      output_action_upper_q <= oct_pkg::RST_BYTE;
      output_action_lower_q <= oct_pkg::RST_BYTE;
      prescale_sel_q        <= 3'h0;
    end
    else if (acc_wr)
    begin
      case (idx_q)
        oct_pkg::IDX_CHANNEL_SELECT: channel_is_compare_q <= HWDATA[7:0];
        oct_pkg::IDX_CH7_MASK:       ch7_output_mask_q <= HWDATA[7:0];
        oct_pkg::IDX_CH7_DATA:       ch7_output_data_q <= HWDATA[7:0];
        oct_pkg::IDX_SYSTEM_CONTROL: control_q <= HWDATA[7:0];
        oct_pkg::IDX_ACTION_UPPER:   output_action_upper_q <= HWDATA[7:0];
        oct_pkg::IDX_ACTION_LOWER:   output_action_lower_q <= HWDATA[7:0];
        oct_pkg::IDX_PRESCALE_SEL:   prescale_sel_q <= HWDATA[2:0];
        default:                     ;
      endcase
    end
  end

  // Compare value registers
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int n = 0; n < CH_COUNT; n++)
        channel_compare_value_q[n] <= oct_pkg::RST_COUNTER;
    end
    else if (acc_wr && idx_q >= oct_pkg::IDX_COMPARE_BASE
             && idx_q <= oct_pkg::IDX_COMPARE_LAST && !idx_q[0])
      channel_compare_value_q[chan_of(idx_q)] <= HWDATA[15:0];
  end

  // Write pulse of the force register, never stored
  assign force_bits = (acc_wr && idx_q == oct_pkg::IDX_COMPARE_FORCE)
                      ? HWDATA[7:0] : 8'h00;

  // Main counter: word write only in special mode, else count on tick
  assign wr_ok = acc_wr && idx_q == oct_pkg::IDX_MAIN_COUNTER && !SPECIAL_MODE_LOW;
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n) main_counter_q <= oct_pkg::RST_COUNTER;
    else if (wr_ok) main_counter_q <= HWDATA[15:0];
    else if (tk.cnt_tick) main_counter_q <= main_counter_q + 16'h0001;
  end

  // Real compares and the actions they or a force trigger
  always_comb
  begin
    for (int n = 0; n < CH_COUNT; n++)
    begin
      match[n] = channel_is_compare_q[n] && tk.cnt_tick
                 && main_counter_q == channel_compare_value_q[n];
      act[n]   = match[n] || force_bits[n];
    end
  end

  // Pin drive and next line level; channel 7 act settled before use
  always_comb
  begin
    for (int n = 0; n < CH_COUNT; n++)
    begin
      drive[n] = (channel_is_compare_q[n] && ch7_output_mask_q[n])
                 || pair_of(output_action_upper_q, output_action_lower_q, n) != 2'b00;
      if (act[7] && ch7_output_mask_q[n])
        line_d[n] = ch7_output_data_q[n];
      else if (act[n] && !ch7_output_mask_q[n])
        line_d[n] = apply_action(pair_of(output_action_upper_q, output_action_lower_q, n),
                                 compare_output_line_q[n]);
      else
        line_d[n] = compare_output_line_q[n];
    end
  end

  // Compare output lines
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n) compare_output_line_q <= oct_pkg::RST_BYTE;
    else compare_output_line_q <= line_d;
  end

  // Pin drive, compare logic overrides direction
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      TIMER_PORT_OUT <= 8'h00;
      TIMER_PORT_OE  <= 8'h00;
    end
    else
    begin
      for (int n = 0; n < CH_COUNT; n++)
      begin
        TIMER_PORT_OUT[n] <= drive[n] ? line_d[n] : PORT_LATCH[n];
        TIMER_PORT_OE[n]  <= drive[n] || PORT_DIRECTION[n];
      end
    end
  end

  // Events, ticks and run levels for the neighbouring logic
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      COMPARE_EVENT  <= 8'h00;
      OVERFLOW_EVENT <= 1'b0;
      DIV64_TICK     <= 1'b0;
      ACC_RUN        <= 1'b0;
      MODULUS_RUN    <= 1'b0;
    end
    else
    begin
      COMPARE_EVENT  <= match;
      OVERFLOW_EVENT <= tk.cnt_tick && !wr_ok && main_counter_q == oct_pkg::COUNTER_TOP;
      DIV64_TICK     <= tk.div64_tick;
      ACC_RUN        <= !stop_wait;
      MODULUS_RUN    <= !stop_wait && !stop_dbg;
    end
  end

  // Fast flag clearing on register access
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CLR_CHANNEL_FLAG      <= 8'h00;
      CLR_OVERFLOW_FLAG     <= 1'b0;
      CLR_ACC_A_FLAGS       <= 1'b0;
      CLR_ACC_B_FLAG        <= 1'b0;
      CLR_MODULUS_ZERO_FLAG <= 1'b0;
    end
    else
    begin
      for (int n = 0; n < CH_COUNT; n++)
        CLR_CHANNEL_FLAG[n] <= fast && sel_ok
          && idx_a >= oct_pkg::IDX_COMPARE_BASE && idx_a <= oct_pkg::IDX_COMPARE_LAST
          && chan_of(idx_a) == n
          && (HWRITE ? channel_is_compare_q[n] : !channel_is_compare_q[n]);
      CLR_OVERFLOW_FLAG <= fast && sel_ok && (idx_a == oct_pkg::IDX_MAIN_COUNTER
                           || idx_a == oct_pkg::IDX_MAIN_COUNTER_L);
      CLR_ACC_A_FLAGS   <= fast && sel_ok && (idx_a == oct_pkg::IDX_PULSE_THREE
                           || idx_a == oct_pkg::IDX_PULSE_TWO);
      CLR_ACC_B_FLAG    <= fast && sel_ok && (idx_a == oct_pkg::IDX_PULSE_ONE
                           || idx_a == oct_pkg::IDX_PULSE_ZERO);
      CLR_MODULUS_ZERO_FLAG <= fast && sel_ok && (idx_a == oct_pkg::IDX_MODULUS_HI
                               || idx_a == oct_pkg::IDX_MODULUS_LO);
    end
  end
endmodule // oct_timer
`default_nettype wire

// ---- testbench/oct_timer_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checks for the compare and counter slice
module oct_timer_props (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        WAIT_MODE,
  input wire logic        DEBUG_MODE,
  input wire logic        DIV64_TICK,
  input wire logic        ACC_RUN,
  input wire logic        MODULUS_RUN,
  input wire logic [7:0]  CLR_CHANNEL_FLAG,
  input wire logic        CLR_OVERFLOW_FLAG,
  input wire logic        CLR_ACC_A_FLAGS,
  input wire logic        CLR_ACC_B_FLAG,
  input wire logic        CLR_MODULUS_ZERO_FLAG
);
  logic       acc;
  logic       fc;
  logic [7:0] idx;
  logic       wr_q;
  logic [7:0] wi_q;
  logic [7:0] ctl_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Address phase decode and fast clear gate
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign idx = HADDR[9:2];
  assign fc  = acc && ctl_q[4];
  // Shadow of the system control byte
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_q  <= 1'b0;
      wi_q  <= 8'h00;
      ctl_q <= 8'h00;
    end
    else
    begin
      wr_q <= acc && HWRITE;
      wi_q <= idx;
      if (wr_q && wi_q == 8'h86) ctl_q <= HWDATA[7:0];
    end
  end
  chk_force_zero: assert property (
    acc && !HWRITE && idx == 8'h81 |=> HRDATA == 32'h00000000)
    else $error("force register read nonzero");
  chk_div64_off: assert property ((!ctl_q[7])[*3] |-> !DIV64_TICK)
    else $error("tick while timer off");
  chk_div64_wait: assert property ((WAIT_MODE && ctl_q[6])[*3] |-> !DIV64_TICK)
    else $error("tick while stopped in wait");
  chk_wait_stop: assert property (
    (WAIT_MODE && ctl_q[6])[*3] |-> !ACC_RUN && !MODULUS_RUN)
    else $error("run level high in wait");
  chk_dbg_mod: assert property ((DEBUG_MODE && ctl_q[5])[*3] |-> !MODULUS_RUN)
    else $error("modulus runs in debug");
  chk_dbg_acc: assert property (
    (DEBUG_MODE && !WAIT_MODE && ctl_q[7])[*3] |-> ACC_RUN)
    else $error("accumulators stopped in debug");
  chk_clr_chan: assert property (
    |CLR_CHANNEL_FLAG |-> $past(fc && idx[7:4] == 4'h9) || $past(fc && idx[7:4] == 4'h9, 2))
    else $error("channel clear without access");
  chk_clr_ovf: assert property (
    fc && idx inside {8'h84, 8'h85} |-> ##[1:2] CLR_OVERFLOW_FLAG)
    else $error("no overflow clear");
  chk_clr_acca: assert property (
    fc && idx inside {8'ha2, 8'ha3} |-> ##[1:2] CLR_ACC_A_FLAGS)
    else $error("no accumulator A clear");
  chk_clr_accb: assert property (
    fc && idx inside {8'ha4, 8'ha5} |-> ##[1:2] CLR_ACC_B_FLAG)
    else $error("no accumulator B clear");
  chk_clr_mod: assert property (
    fc && idx inside {8'hb6, 8'hb7} |-> ##[1:2] CLR_MODULUS_ZERO_FLAG)
    else $error("no modulus zero clear");
  cov_div64: cover property (DIV64_TICK);
  cov_ovf_clr: cover property (CLR_OVERFLOW_FLAG);
  cov_wait: cover property (WAIT_MODE && !ACC_RUN);
endmodule // oct_timer_props
bind oct_timer oct_timer_props oct_timer_props_i (
  .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .WAIT_MODE(WAIT_MODE), .DEBUG_MODE(DEBUG_MODE), .DIV64_TICK(DIV64_TICK),
  .ACC_RUN(ACC_RUN), .MODULUS_RUN(MODULUS_RUN), .CLR_CHANNEL_FLAG(CLR_CHANNEL_FLAG),
  .CLR_OVERFLOW_FLAG(CLR_OVERFLOW_FLAG), .CLR_ACC_A_FLAGS(CLR_ACC_A_FLAGS),
  .CLR_ACC_B_FLAG(CLR_ACC_B_FLAG), .CLR_MODULUS_ZERO_FLAG(CLR_MODULUS_ZERO_FLAG)
);
`default_nettype wire

// ---- testbench/oct_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Timer port pads seen from the board
module oct_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_level
);
  logic [7:0] last_q = 8'h00;
  // Undriven pads flip every cycle, so a stale level never reads as valid
  always @(posedge clk)
  begin
    last_q <= pin_level;
  end
  assign pin_level = (pin_out & pin_oe) | (~last_q & ~pin_oe);
endmodule // oct_pin_model
`default_nettype wire

// ---- testbench/test_output_compare_timer_control.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the compare and counter slice
module test_output_compare_timer_control;
  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] wdat;
    logic [15:0] rexp;
  } oct_row_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [7:0]  port_dir = 8'h00;
  logic        special_mode_low = 1'b1;
  logic        wait_mode = 1'b0;
  logic        dbg_mode = 1'b0;
  logic        mon_clr = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pin_lvl;
  logic [7:0]  cmp_ev;
  logic        ovf_ev;
  logic        div64;
  logic        acc_run;
  logic        mod_run;
  logic [7:0]  clr_ch;
  logic [3:0]  clr_misc;
  logic [20:0] seen_q = '0;
  logic [31:0] rd;
  logic [31:0] rd0;
  int          div_cnt = 0;
  int          cycles = 0;
  int          err_count = 0;
  int          samples_checked = 0;
  oct_row_s    rows [10] = '{{8'h82, 16'h00a5, 16'h00a5}, {8'h83, 16'h005a, 16'h005a},
    {8'h88, 16'h00c3, 16'h00c3}, {8'h89, 16'h003c, 16'h003c}, {8'h80, 16'h00ff, 16'h00ff},
    {8'h81, 16'h0000, 16'h0000}, {8'h86, 16'h0010, 16'h0010}, {8'h87, 16'h00ff, 16'h0000},
    {8'h84, 16'h1234, 16'h0000}, {8'h40, 16'h00ff, 16'h0000}};
  oct_row_s    fast [11] = '{{8'h84, 16'h0, 16'h008}, {8'h85, 16'h0, 16'h008},
    {8'ha2, 16'h0, 16'h004}, {8'ha3, 16'h0, 16'h004}, {8'ha4, 16'h0, 16'h002},
    {8'ha5, 16'h0, 16'h002}, {8'hb6, 16'h0, 16'h001}, {8'hb7, 16'h0, 16'h001},
    {8'h92, 16'h1, 16'h020}, {8'h92, 16'h0, 16'h000}, {8'h9e, 16'h1, 16'h800}};
  oct_timer oct_timer_i (
    .CLK(clk), .RSTN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PORT_DIRECTION(port_dir),
    .PORT_LATCH(8'h00), .SPECIAL_MODE_LOW(special_mode_low), .WAIT_MODE(wait_mode),
    .DEBUG_MODE(dbg_mode), .TIMER_PORT_OUT(pin_out), .TIMER_PORT_OE(pin_oe),
    .COMPARE_EVENT(cmp_ev), .OVERFLOW_EVENT(ovf_ev), .DIV64_TICK(div64),
    .ACC_RUN(acc_run), .MODULUS_RUN(mod_run), .CLR_CHANNEL_FLAG(clr_ch),
    .CLR_OVERFLOW_FLAG(clr_misc[3]), .CLR_ACC_A_FLAGS(clr_misc[2]),
    .CLR_ACC_B_FLAG(clr_misc[1]), .CLR_MODULUS_ZERO_FLAG(clr_misc[0]));
  oct_pin_model oct_pin_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_lvl));
  // Clock
  always #2.5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Sticky pulse record, tick count and hang limit
  always @(posedge clk)
  begin
    seen_q <= mon_clr ? 21'h0 : seen_q | {cmp_ev, ovf_ev, clr_ch, clr_misc};
    div_cnt <= mon_clr ? 0 : div_cnt + int'(div64);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One whole-word transfer; the counter is never split into bytes
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     output logic [31:0] rdat);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d, rd);
    tick(1);
  endtask
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000, rd);
    check(what, rd, {16'h0000, exp});
  endtask
  task automatic frc(input logic [7:0] d);
    wr(8'h81, {8'h00, d});
    tick(2);
  endtask
  task automatic mclr;
    mon_clr <= 1'b1;
    @(posedge clk);
    mon_clr <= 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    check("resp", {hreadyout, hresp, pin_oe}, 10'h200);
    $display("reset test done");
    foreach (rows[i])
    begin
      rdchk("reset", rows[i].idx, 16'h0000);
      bus(1'b1, rows[i].idx, rows[i].wdat, rd);
      tick(1);
      rdchk("reg", rows[i].idx, rows[i].rexp);
    end
    $display("register rows done");
    // Forced actions, channel 7 mask and data
    wr(8'h82, 16'h0034);
    wr(8'h83, 16'h0014);
    wr(8'h88, 16'h0000);
    wr(8'h89, 16'h00e4);
    mclr();
    frc(8'h0f);
    check("oe", pin_oe, 8'h3e);
    check("pin", pin_lvl & 8'h0a, 8'h0a);
    wr(8'h83, 16'h0010);
    frc(8'h80);
    check("pin", pin_lvl & 8'h34, 8'h10);
    wr(8'h83, 16'h0014);
    frc(8'h84);
    check("pin", pin_lvl & 8'h34, 8'h14);
    frc(8'h04);
    check("pin", pin_lvl & 8'h34, 8'h14);
    frc(8'h02);
    check("pin", pin_lvl & 8'h02, 8'h00);
    check("event", seen_q[20:13], 8'h00);
    $display("force test done");
    // Counter load, run, compare and overflow
    special_mode_low <= 1'b0;
    wr(8'h8d, 16'h0000);
    wr(8'h90, 16'hfff8);
    wr(8'h84, 16'hfff0);
    rdchk("cnt", 8'h84, 16'hfff0);
    tick(4);
    rdchk("cnt", 8'h84, 16'hfff0);
    mclr();
    wr(8'h86, 16'h0080);
    tick(40);
    check("ovf", seen_q[12], 1'b1);
    check("cmp", seen_q[13], 1'b1);
    mclr();
    tick(257);
    check("div64", div_cnt, 4);
    wr(8'h86, 16'h0000);
    mclr();
    tick(130);
    check("div64", div_cnt, 0);
    // Prescale factor eight: 64 cycles apart give 8 counts
    wr(8'h8d, 16'h0003);
    wr(8'h86, 16'h0080);
    tick(140);
    bus(1'b0, 8'h84, 16'h0000, rd0);
    tick(62);
    bus(1'b0, 8'h84, 16'h0000, rd);
    check("prescale", rd - rd0, 32'h0000_0008);
    wr(8'h86, 16'h0000);
    $display("counter test done");
    // Wait and debug stops
    wr(8'h86, 16'h00e0);
    wait_mode <= 1'b1;
    mclr();
    tick(130);
    check("run", {acc_run, mod_run}, 2'b00);
    check("div64", div_cnt, 0);
    wait_mode <= 1'b0;
    dbg_mode <= 1'b1;
    tick(4);
    check("run", {acc_run, mod_run}, 2'b10);
    dbg_mode <= 1'b0;
    wr(8'h86, 16'h0080);
    wait_mode <= 1'b1;
    tick(4);
    check("run", acc_run, 1'b1);
    wait_mode <= 1'b0;
    $display("stop test done");
    // Fast flag clearing per access
    wr(8'h86, 16'h0090);
    foreach (fast[i])
    begin
      mclr();
      bus(fast[i].wdat[0], fast[i].idx, 16'h1234, rd);
      tick(3);
      check("clr", seen_q[11:0], fast[i].rexp[11:0]);
    end
    wr(8'h80, 16'h0000);
    mclr();
    bus(1'b0, 8'h92, 16'h0000, rd);
    tick(3);
    check("clr", seen_q[11:0], 12'h020);
    port_dir <= 8'h40;
    tick(3);
    check("oe", pin_oe, 8'h4e);
    wr(8'h86, 16'h0080);
    mclr();
    bus(1'b0, 8'h84, 16'h0000, rd);
    tick(3);
    check("clr", seen_q[11:0], 12'h000);
    $display("fast clear test done");
    end_sim();
  end
endmodule // test_output_compare_timer_control
`default_nettype wire
